/* hw/thrcmp_pkg.sv */
// Constants for the threshold comparator control block
// Operation
// [R1] Top code bit selects upper levels 32-63
// [R2] Top code bit zero selects lower levels
// [R3] Loop mode compares against error amplifier
// [R4] Result low below reference or disabled
// [R5] Result rising edge starts cutoff signal; the code does so only while delay filter bit 5 is clear
// [R6] Select bit six picks sense pin
// [R7] Software tri-states sense pin before enabling
// [R8] Reference bit one picks level or amplifier
// [R9] Enable bit seven gates comparator result
// [R10] Result sampled each clock into status
// [R11] Status bit read-only, no side effects
// [R12] Controls reset to zero, comparator off
package thrcmp_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int MV_W = 12;

  // *************************************************
  // Register indices; byte address is four times index
  // *************************************************
  localparam logic [ADDR_W-1:0] IDX_COMP_CTRL = 10'h0A1;
  localparam logic [ADDR_W-1:0] IDX_DELAY_FILTER = 10'h0A2;
  localparam logic [ADDR_W-1:0] IDX_CONV_CTRL_TWO = 10'h0A3;
  localparam logic [ADDR_W-1:0] ADDR_COMP_CTRL = 10'(IDX_COMP_CTRL * 4);
  localparam logic [ADDR_W-1:0] ADDR_DELAY_FILTER =
    10'(IDX_DELAY_FILTER * 4);
  localparam logic [ADDR_W-1:0] ADDR_CONV_CTRL_TWO =
    10'(IDX_CONV_CTRL_TWO * 4);

  // *************************************************
  // Field positions
  // *************************************************
  localparam int COMP_LEVEL_LSB = 2;
  localparam int COMP_LEVEL_W = 6;
  localparam int COMP_LOOP_BIT = 1;
  localparam int COMP_RESULT_BIT = 0;
  localparam int DLY_ENABLE_BIT = 7;
  localparam int DLY_FILTER_N_BIT = 5;
  localparam int CONV_SELECT_BIT = 6;

  // *************************************************
  // Reset values
  // *************************************************
  localparam logic [DATA_W-1:0] COMP_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DELAY_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CONV_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

  // Threshold in millivolts per level code; code 0 has no level, taken as 0
  localparam logic [0:63][MV_W-1:0] LEVEL_MV = '{
    12'h000, 12'h023, 12'h032, 12'h040, 12'h04E, 12'h05D, 12'h06B, 12'h079,
    12'h087, 12'h096, 12'h0A4, 12'h0B2, 12'h0C0, 12'h0CD, 12'h0DB, 12'h0E9,
    12'h0F7, 12'h105, 12'h112, 12'h120, 12'h12E, 12'h13C, 12'h14A, 12'h157,
    12'h166, 12'h173, 12'h181, 12'h191, 12'h19D, 12'h1AD, 12'h1BB, 12'h1CB,
    12'h1CC, 12'h1FE, 12'h230, 12'h262, 12'h294, 12'h2C6, 12'h2F8, 12'h32A,
    12'h35C, 12'h38E, 12'h3C0, 12'h3F2, 12'h424, 12'h456, 12'h488, 12'h4BA,
    12'h4F6, 12'h528, 12'h55A, 12'h596, 12'h5C8, 12'h5FA, 12'h62C, 12'h65E,
    12'h690, 12'h6C2, 12'h6F4, 12'h726, 12'h758, 12'h794, 12'h7C6, 12'h7F8
  };

endpackage

/* hw/thrcmp_top.sv */
// Threshold comparator control: registers, compare, sampling, cutoff edge
`timescale 1ns/1ps
`default_nettype none
module thrcmp_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [thrcmp_pkg::ADDR_W-1:0] regAddr,
  input wire logic [thrcmp_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [thrcmp_pkg::DATA_W-1:0] regRdData,
  input wire logic [thrcmp_pkg::MV_W-1:0] sensePinZero,
  input wire logic [thrcmp_pkg::MV_W-1:0] sensePinTwo,
  input wire logic [thrcmp_pkg::MV_W-1:0] errorAmpOutput,
  output logic analogCheckEnable,
  output logic senseInputSelect,
  output logic loopModeSelect,
  output logic [thrcmp_pkg::COMP_LEVEL_W-1:0] thresholdLevelCode,
  output logic resultStatusBit,
  output logic driveCutoffSignal
);

  // *************************************************
  // Register storage
  // *************************************************
  localparam int LEVEL_COUNT = 1 << thrcmp_pkg::COMP_LEVEL_W;

  // Comparator control fields; its status bit lives in result_r
  logic [thrcmp_pkg::COMP_LEVEL_W-1:0] levelCode_r;
  logic [thrcmp_pkg::COMP_LEVEL_W-1:0] levelCode_nxt;
  logic loopMode_r;
  logic loopMode_nxt;

  // Kept whole so software reads back the inert bits
  logic [thrcmp_pkg::DATA_W-1:0] delayFilterReg_r;
  logic [thrcmp_pkg::DATA_W-1:0] delayFilterReg_nxt;
  logic [thrcmp_pkg::DATA_W-1:0] convCtrlTwo_r;
  logic [thrcmp_pkg::DATA_W-1:0] convCtrlTwo_nxt;

  // Sampling, cutoff and read data
  logic result_r;
  logic result_nxt;
  logic cutoff_r;
  logic cutoff_nxt;
  logic [thrcmp_pkg::DATA_W-1:0] rdData_r;
  logic [thrcmp_pkg::DATA_W-1:0] rdData_nxt;

  // Compare path nets
  logic compEnable;
  logic filterEnableN;
  logic senseSelect;
  logic [thrcmp_pkg::MV_W-1:0] senseMv;
  logic [LEVEL_COUNT-1:0] aboveLevel;
  logic aboveAmp;
  logic aboveRef;
  logic rawResult;
  logic resultRise;

  // *************************************************
  // Decode helpers
  // *************************************************
  function automatic logic hit(
    input logic [thrcmp_pkg::ADDR_W-1:0] a,
    input logic [thrcmp_pkg::ADDR_W-1:0] target
  );
    hit = (a == target);
  endfunction

  function automatic logic strobeHit(
    input logic strobe,
    input logic [thrcmp_pkg::ADDR_W-1:0] a,
    input logic [thrcmp_pkg::ADDR_W-1:0] target
  );
    strobeHit = strobe && hit(a, target);
  endfunction

  // *************************************************
  // Register write decode
  // *************************************************
  // Status bit of the written byte is dropped: it is not writable
  always_comb begin
    levelCode_nxt = levelCode_r;
    loopMode_nxt = loopMode_r;
    if (strobeHit(regWrite, regAddr, thrcmp_pkg::ADDR_COMP_CTRL)) begin
      levelCode_nxt =
        regWrData[thrcmp_pkg::COMP_LEVEL_LSB +: thrcmp_pkg::COMP_LEVEL_W];
      loopMode_nxt = regWrData[thrcmp_pkg::COMP_LOOP_BIT];
    end
  end

  always_comb begin
    delayFilterReg_nxt = delayFilterReg_r;
    if (strobeHit(regWrite, regAddr, thrcmp_pkg::ADDR_DELAY_FILTER)) begin
      delayFilterReg_nxt = regWrData;
    end
  end

  always_comb begin
    convCtrlTwo_nxt = convCtrlTwo_r;
    if (strobeHit(regWrite, regAddr, thrcmp_pkg::ADDR_CONV_CTRL_TWO)) begin
      convCtrlTwo_nxt = regWrData;
    end
  end

  // *************************************************
  // Register flops
  // *************************************************
  // [R12] Level code clears on reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      levelCode_r <= thrcmp_pkg::COMP_RESET[
        thrcmp_pkg::COMP_LEVEL_LSB +: thrcmp_pkg::COMP_LEVEL_W];
    end else begin
      levelCode_r <= levelCode_nxt;
    end
  end

  // [R12] Loop mode clears on reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loopMode_r <= thrcmp_pkg::COMP_RESET[thrcmp_pkg::COMP_LOOP_BIT];
    end else begin
      loopMode_r <= loopMode_nxt;
    end
  end

  // [R12] Enable clears: comparator starts off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      delayFilterReg_r <= thrcmp_pkg::DELAY_RESET;
    end else begin
      delayFilterReg_r <= delayFilterReg_nxt;
    end
  end

  // [R12] Input select clears on reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      convCtrlTwo_r <= thrcmp_pkg::CONV_RESET;
    end else begin
      convCtrlTwo_r <= convCtrlTwo_nxt;
    end
  end

  // *************************************************
  // Compare path
  // *************************************************
  always_comb begin
    compEnable = delayFilterReg_r[thrcmp_pkg::DLY_ENABLE_BIT];
    filterEnableN = delayFilterReg_r[thrcmp_pkg::DLY_FILTER_N_BIT];
    senseSelect = convCtrlTwo_r[thrcmp_pkg::CONV_SELECT_BIT];
  end

  // [R6] Sense pin choice
  always_comb begin
    senseMv = senseSelect ? sensePinTwo : sensePinZero;
  end

  // [R1] [R2] One strict compare per level
  // Costs area, but keeps the level mux after the compares
  genvar lvl;
  generate
    for (lvl = 0; lvl < LEVEL_COUNT; lvl++) begin : g_level
      assign aboveLevel[lvl] = senseMv > thrcmp_pkg::LEVEL_MV[lvl];
    end
  endgenerate

  // [R3] Loop against amplifier
  always_comb begin
    aboveAmp = senseMv > errorAmpOutput;
  end

  // [R8] Reference source choice
  always_comb begin
    if (loopMode_r) begin
      aboveRef = aboveAmp;
    end else begin
      aboveRef = aboveLevel[levelCode_r];
    end
  end

  // [R4] [R9] Low unless enabled and above
  // Equal to the reference counts as below: no hysteresis
  always_comb begin
    rawResult = compEnable && aboveRef;
  end

  // *************************************************
  // Sampling and cutoff edge
  // *************************************************
  // [R10] Sample every clock
  always_comb begin
    result_nxt = rawResult;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_r <= 1'b0;
    end else begin
      result_r <= result_nxt;
    end
  end

  // [R5] Rising edge pulses cutoff while delay filter bit 5 is clear
  // Delay counter left out, so the pulse rises in the same cycle as the status bit
  always_comb begin
    resultRise = rawResult && !result_r;
    cutoff_nxt = !filterEnableN && resultRise;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cutoff_r <= 1'b0;
    end else begin
      cutoff_r <= cutoff_nxt;
    end
  end

  // *************************************************
  // Read port
  // *************************************************
  // [R11] Status only readable
  always_comb begin
    rdData_nxt = thrcmp_pkg::READ_IDLE;
    if (strobeHit(regRead, regAddr, thrcmp_pkg::ADDR_COMP_CTRL)) begin
      rdData_nxt[thrcmp_pkg::COMP_LEVEL_LSB +: thrcmp_pkg::COMP_LEVEL_W] =
        levelCode_r;
      rdData_nxt[thrcmp_pkg::COMP_LOOP_BIT] = loopMode_r;
      rdData_nxt[thrcmp_pkg::COMP_RESULT_BIT] = result_r;
    end else if (strobeHit(regRead, regAddr,
                           thrcmp_pkg::ADDR_DELAY_FILTER)) begin
      rdData_nxt = delayFilterReg_r;
    end else if (strobeHit(regRead, regAddr,
                           thrcmp_pkg::ADDR_CONV_CTRL_TWO)) begin
      rdData_nxt = convCtrlTwo_r;
    end
  end

  // Idle value between reads keeps stale data off the bus
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_r <= thrcmp_pkg::READ_IDLE;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  // *************************************************
  // Outputs, each straight from its flop
  // *************************************************
  assign regRdData = rdData_r;

  assign analogCheckEnable = delayFilterReg_r[thrcmp_pkg::DLY_ENABLE_BIT];

  assign senseInputSelect = convCtrlTwo_r[thrcmp_pkg::CONV_SELECT_BIT];

  assign loopModeSelect = loopMode_r;

  assign thresholdLevelCode = levelCode_r;

  assign resultStatusBit = result_r;

  assign driveCutoffSignal = cutoff_r;

endmodule
`default_nettype wire

/* verif/thrcmp_asserts.sv */
// Port checker for threshold comparator control
`timescale 1ns/1ps
`default_nettype none
module thrcmp_asserts (
  input wire logic clk, rst, regWrite, regRead, analogCheckEnable,
  input wire logic loopModeSelect, resultStatusBit, driveCutoffSignal,
  input wire logic [9:0] regAddr,
  input wire logic [7:0] regWrData, regRdData
);
  wire logic cw = regWrite && regAddr == thrcmp_pkg::ADDR_COMP_CTRL;
  wire logic dw = regWrite && regAddr == thrcmp_pkg::ADDR_DELAY_FILTER;
  wire logic cr = regRead && regAddr == thrcmp_pkg::ADDR_COMP_CTRL;
  default clocking @(posedge clk); endclocking default disable iff (rst);
  property p_off; !analogCheckEnable |=> !resultStatusBit; endproperty
  a_off: assert property (p_off) else $error("high when off");
  property p_cut; driveCutoffSignal |-> $rose(resultStatusBit); endproperty
  a_cut: assert property (p_cut) else $error("cut no edge");
  property p_cen; driveCutoffSignal |-> $past(analogCheckEnable); endproperty
  a_cen: assert property (p_cen) else $error("cut when off");
  property p_rd; cr |=> regRdData[0] == $past(resultStatusBit); endproperty
  a_rd: assert property (p_rd) else $error("status read");
  property p_en; dw |=> analogCheckEnable == $past(regWrData[7]); endproperty
  a_en: assert property (p_en) else $error("enable bit");
  property p_loop; cw |=> loopModeSelect == $past(regWrData[1]); endproperty
  a_loop: assert property (p_loop) else $error("loop bit");
  property p_ro; cw && !analogCheckEnable |=> !resultStatusBit; endproperty
  a_ro: assert property (p_ro) else $error("status written");
  property p_rst; $fell(rst) |-> !analogCheckEnable && !loopModeSelect;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  c_cut: cover property (driveCutoffSignal);
  c_rd: cover property (cr ##1 regRdData[0]);
  c_fall: cover property ($fell(resultStatusBit));
endmodule
bind thrcmp_top thrcmp_asserts thrcmp_asserts_inst (.*);
`default_nettype wire

/* verif/thrcmp_partner.sv */
// Analog source model for sense pins and error amplifier
`timescale 1ns/1ps
`default_nettype none
module thrcmp_partner (
  input wire logic clk,
  input wire logic [35:0] setMv,
  output logic [11:0] sensePinZero, sensePinTwo, errorAmpOutput
);
  always_ff @(posedge clk)
    {sensePinZero, sensePinTwo, errorAmpOutput} <= setMv;
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Directed bench for threshold comparator control
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic [9:0] regAddr = '0;
  logic [7:0] regWrData = '0;
  logic [35:0] setMv = '0;
  wire [7:0] regRdData;
  wire [11:0] sensePinZero, sensePinTwo, errorAmpOutput;
  wire resultStatusBit, driveCutoffSignal, senseInputSelect;
  wire [5:0] thresholdLevelCode;
  int error_cnt = 0, cmp_count = 0, cuts = 0;
  thrcmp_partner thrcmp_partner_inst (.*);
  thrcmp_top thrcmp_top_inst (.*, .analogCheckEnable(),
    .loopModeSelect());
  initial forever #20 clk = ~clk;
  always @(posedge clk) cuts <= cuts + (driveCutoffSignal === 1'b1);
  task chk(string nm, logic [11:0] seen, exp);
    cmp_count++;
    if (seen !== exp) error_cnt++;
    if (seen !== exp) $display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
  endtask
  task acc(logic w, logic [9:0] a, logic [7:0] d);
    @(posedge clk);
    {regWrite, regRead, regAddr, regWrData} <= {w, !w, a, d};
    @(posedge clk);
    {regWrite, regRead} <= 2'h0;
    if (!w) #1 chk("read", 12'(regRdData), 12'(d));
  endtask
  task run(logic [7:0] c, v, d, logic [35:0] mv, logic r, n);
    cuts = 0;
    acc(1'b1, thrcmp_pkg::ADDR_CONV_CTRL_TWO, v);
    acc(1'b1, thrcmp_pkg::ADDR_COMP_CTRL, c);
    acc(1'b1, thrcmp_pkg::ADDR_DELAY_FILTER, d);
    setMv <= mv;
    repeat (4) @(posedge clk);
    #1 chk("cutoffs", 12'(cuts), 12'(n));
    chk("level", 12'(thresholdLevelCode), 12'(c[7:2]));
    chk("select", 12'(senseInputSelect), 12'(v[6]));
    acc(1'b0, thrcmp_pkg::ADDR_COMP_CTRL, {c[7:1], r});
  endtask
  task end_sim();
    $display("mismatches %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    acc(1'b0, 10'h000, 8'h00);
    run(8'h80, 8'h00, 8'h80, 36'h1CD000000, 1'b1, 1'b1);
    run(8'h7C, 8'h00, 8'h80, 36'h1CB000000, 1'b0, 1'b0);
    run(8'hFE, 8'h00, 8'h80, 36'h12D00012C, 1'b1, 1'b1);
    run(8'h80, 8'h40, 8'hA0, 36'h000384000, 1'b1, 1'b0);
    run(8'h81, 8'h40, 8'h20, 36'h000384000, 1'b0, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
